/* File: verilog/mip_ctrl.sv */
`timescale 1ns/1ns
// Functional notes
// - Four levels, zero most urgent, three least.
// - More urgent request preempts running less urgent level.
// - Fixed sources per level: checks, disk, I/O, options.
// - Display and diskette have no request input.
// - Parity, address, microprogram, port checks raise zero.
// - Level two order: comm adapter, keyboard, printer.
// - Level zero shares main bank; others own.
// - Level three uses first ten optional entries.
// - Levels four, five reserved; entries 2A-3F unused.
// - Each set: eight words, next, return address.
// - Main/zero words at 00-07, addresses 08-0B.
// - Level one words 10-17, two 18-1F.
// - Level three words 20-27, addresses 28-29.
module mip_ctrl #(
  parameter logic [15:0] VEC_L0 = 16'h0100,
  parameter logic [15:0] VEC_L1 = 16'h0200,
  parameter logic [15:0] VEC_L2 = 16'h0300,
  parameter logic [15:0] VEC_L3 = 16'h0400
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic parity_chk,
  input wire logic bad_addr_chk,
  input wire logic uprog_chk,
  input wire logic port_chk,
  input wire logic disk_req,
  input wire logic comm_line_adapter_req,
  input wire logic kbd_req,
  input wire logic prn_req,
  input wire logic opt_card_req,
  input wire logic opt_reader_req,
  input wire logic opt_recorder_req,
  input wire logic instr_boundary,
  input wire logic level_exit,
  input wire logic [3:0] reg_sel,
  input wire logic reg_we,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic [2:0] active_level,
  output logic level_entry,
  output logic [2:0] entry_level,
  output logic [3:0] check_cause,
  output logic [3:0] pending_levels,
  output logic [2:0] l2_source,
  output logic [2:0] l3_source
);
  typedef struct packed {
    logic [6:0] sy1;
    logic [6:0] sy2;
    logic l0_pend;
    logic [3:0] cause;
    logic l1_pend;
    logic [2:0] l2_pend;
    logic [2:0] l3_pend;
    logic [3:0] inprog;
    logic [2:0] cur;
    logic [2:0] l2_svc;
    logic [2:0] l3_svc;
    logic take;
    logic [2:0] take_lvl;
    logic [15:0] rd_data;
    logic [41:0][15:0] stack;
  } mip_state_t;

  localparam mip_state_t MIP_RESET = '{cur: mip_pkg::LVL_MAIN, default: '0};

  if (mip_pkg::STACK_USED != int'(mip_pkg::RSV_FIRST) || mip_pkg::DATA_W != 16) begin : g_chk
    $error("mip_ctrl: stack layout does not match the level banks");
  end

  mip_state_t q, d;
  mip_map_if map_bus ();
  logic [6:0] raw_req;
  logic [3:0] lvl_pend;
  logic [2:0] want_lvl;
  logic [2:0] l2_pick;
  logic [2:0] l3_pick;
  logic [3:0] new_chk;
  logic taking;
  logic leaving;

  mip_bank_map u_map (
    .m(map_bus.mapper)
  );

  // Display and diskette drive deliberately have no entry here
  always_comb begin
    raw_req = '0;
    raw_req[mip_pkg::SY_DISK] = disk_req;
    raw_req[mip_pkg::SY_COMM] = comm_line_adapter_req;
    raw_req[mip_pkg::SY_KBD] = kbd_req;
    raw_req[mip_pkg::SY_PRN] = prn_req;
    raw_req[mip_pkg::SY_CARD] = opt_card_req;
    raw_req[mip_pkg::SY_READER] = opt_reader_req;
    raw_req[mip_pkg::SY_RECORDER] = opt_recorder_req;
  end

  // Checkers sit on this clock, so their pulses need no synchroniser
  always_comb begin
    new_chk = '0;
    new_chk[mip_pkg::CK_PARITY] = parity_chk;
    new_chk[mip_pkg::CK_ADDR] = bad_addr_chk;
    new_chk[mip_pkg::CK_UPROG] = uprog_chk;
    new_chk[mip_pkg::CK_PORT] = port_chk;
  end

  always_comb begin
    lvl_pend = {|q.l3_pend, |q.l2_pend, q.l1_pend, q.l0_pend};
    want_lvl = mip_pkg::top_level(lvl_pend);
    l2_pick = mip_pkg::pick3(q.l2_pend);
    l3_pick = mip_pkg::pick3(q.l3_pend);
    leaving = level_exit && (q.cur != mip_pkg::LVL_MAIN);
    // Switch only between instructions; an exit in the same cycle blocks entry until a later boundary without an exit
    taking = instr_boundary && !level_exit && (want_lvl < q.cur);
  end

  always_comb begin
    map_bus.level = q.cur;
    map_bus.sel = reg_sel;
  end

  always_comb begin
    d = q;
    d.take = 1'b0;
    d.sy1 = raw_req;
    d.sy2 = q.sy1;

    // Pending bits: a new request beats a clear in the same cycle
    if (taking && want_lvl == mip_pkg::LVL_0) begin
      d.l0_pend = 1'b0;
    end
    if (taking && want_lvl == mip_pkg::LVL_1) begin
      d.l1_pend = 1'b0;
    end
    if (taking && want_lvl == mip_pkg::LVL_2) begin
      d.l2_pend = q.l2_pend & ~l2_pick;
      d.l2_svc = l2_pick;
    end
    if (taking && want_lvl == mip_pkg::LVL_3) begin
      d.l3_pend = q.l3_pend & ~l3_pick;
      d.l3_svc = l3_pick;
    end
    if (leaving && q.cur == mip_pkg::LVL_0) begin
      d.cause = '0;
    end
    d.l0_pend = d.l0_pend | (|new_chk);
    d.cause = d.cause | new_chk;
    d.l1_pend = d.l1_pend | q.sy2[mip_pkg::SY_DISK];
    d.l2_pend = d.l2_pend | {q.sy2[mip_pkg::SY_PRN], q.sy2[mip_pkg::SY_KBD], q.sy2[mip_pkg::SY_COMM]};
    d.l3_pend = d.l3_pend | {q.sy2[mip_pkg::SY_RECORDER], q.sy2[mip_pkg::SY_READER], q.sy2[mip_pkg::SY_CARD]};

    // Interrupted levels stay marked so that an exit resumes the most urgent one
    if (leaving) begin
      d.inprog[q.cur[1:0]] = 1'b0;
    end
    if (taking) begin
      d.inprog[want_lvl[1:0]] = 1'b1;
      d.take = 1'b1;
      d.take_lvl = want_lvl;
    end
    d.cur = mip_pkg::top_level(d.inprog);

    // Register stack access through the bank of the running level
    d.rd_data = map_bus.hit ? q.stack[map_bus.idx] : '0;
    if (reg_we && map_bus.hit) begin
      d.stack[map_bus.idx] = reg_wdata;
    end
    // Entry loads the new level's next address; it wins over a port write to it
    if (taking) begin
      case (want_lvl)
        mip_pkg::LVL_0: d.stack[mip_pkg::NIA_L0] = VEC_L0;
        mip_pkg::LVL_1: d.stack[mip_pkg::NIA_L1] = VEC_L1;
        mip_pkg::LVL_2: d.stack[mip_pkg::NIA_L2] = VEC_L2;
        default: d.stack[mip_pkg::NIA_L3] = VEC_L3;
      endcase
    end
  end

  // Entries 2A-3F are never built, so the reserved levels cannot disturb anything
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= MIP_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  always_comb begin
    reg_rdata = q.rd_data;
    active_level = q.cur;
    level_entry = q.take;
    entry_level = q.take_lvl;
    check_cause = q.cause;
    pending_levels = {|q.l3_pend, |q.l2_pend, q.l1_pend, q.l0_pend};
    l2_source = q.l2_svc;
    l3_source = q.l3_svc;
  end
endmodule : mip_ctrl

/* File: verilog/mip_pkg.sv */
package mip_pkg;
  localparam int DATA_W = 16;
  localparam int NUM_LVL = 4;
  localparam int WR_PER_LVL = 8;
  localparam int STACK_DEPTH = 64;
  localparam int STACK_USED = 42;
  localparam logic [2:0] LVL_0 = 3'h0;
  localparam logic [2:0] LVL_1 = 3'h1;
  localparam logic [2:0] LVL_2 = 3'h2;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_MAIN = 3'h4;
  localparam logic [5:0] WR_BASE_MAIN = 6'h00;
  localparam logic [5:0] WR_BASE_L1 = 6'h10;
  localparam logic [5:0] WR_BASE_L2 = 6'h18;
  localparam logic [5:0] WR_BASE_L3 = 6'h20;
  localparam logic [5:0] NIA_MAIN = 6'h08;
  localparam logic [5:0] RET_MAIN = 6'h09;
  localparam logic [5:0] NIA_L0 = 6'h0A;
  localparam logic [5:0] RET_L0 = 6'h0B;
  localparam logic [5:0] NIA_L1 = 6'h0C;
  localparam logic [5:0] RET_L1 = 6'h0D;
  localparam logic [5:0] NIA_L2 = 6'h0E;
  localparam logic [5:0] RET_L2 = 6'h0F;
  localparam logic [5:0] NIA_L3 = 6'h28;
  localparam logic [5:0] RET_L3 = 6'h29;
  localparam logic [5:0] RSV_FIRST = 6'h2A;
  localparam logic [5:0] RSV_LAST = 6'h3F;
  localparam logic [3:0] SEL_NIA = 4'h8;
  localparam logic [3:0] SEL_RET = 4'h9;
  localparam int CK_PARITY = 0;
  localparam int CK_ADDR = 1;
  localparam int CK_UPROG = 2;
  localparam int CK_PORT = 3;
  localparam int L2_COMM = 0;
  localparam int L2_KBD = 1;
  localparam int L2_PRN = 2;
  localparam int L3_CARD = 0;
  localparam int L3_READER = 1;
  localparam int L3_RECORDER = 2;
  localparam int SY_DISK = 0;
  localparam int SY_COMM = 1;
  localparam int SY_KBD = 2;
  localparam int SY_PRN = 3;
  localparam int SY_CARD = 4;
  localparam int SY_READER = 5;
  localparam int SY_RECORDER = 6;
  localparam int SY_W = 7;

  // Lowest set bit wins, level 0 being the most urgent; empty mask means main level
  function automatic logic [2:0] top_level(input logic [3:0] m);
    top_level = LVL_MAIN;
    for (int i = NUM_LVL - 1; i >= 0; i--) begin
      if (m[i]) begin
        top_level = 3'(i);
      end
    end
  endfunction : top_level

  // One-hot pick of the first set bit among three sharers of a level
  function automatic logic [2:0] pick3(input logic [2:0] v);
    pick3 = 3'h0;
    if (v[0]) begin
      pick3 = 3'h1;
    end else if (v[1]) begin
      pick3 = 3'h2;
    end else if (v[2]) begin
      pick3 = 3'h4;
    end
  endfunction : pick3

  function automatic logic [5:0] wr_base(input logic [2:0] lvl);
    case (lvl)
      LVL_1: wr_base = WR_BASE_L1;
      LVL_2: wr_base = WR_BASE_L2;
      LVL_3: wr_base = WR_BASE_L3;
      default: wr_base = WR_BASE_MAIN;
    endcase
  endfunction : wr_base

  function automatic logic [5:0] nia_of(input logic [2:0] lvl);
    case (lvl)
      LVL_0: nia_of = NIA_L0;
      LVL_1: nia_of = NIA_L1;
      LVL_2: nia_of = NIA_L2;
      LVL_3: nia_of = NIA_L3;
      default: nia_of = NIA_MAIN;
    endcase
  endfunction : nia_of

  function automatic logic [5:0] ret_of(input logic [2:0] lvl);
    case (lvl)
      LVL_0: ret_of = RET_L0;
      LVL_1: ret_of = RET_L1;
      LVL_2: ret_of = RET_L2;
      LVL_3: ret_of = RET_L3;
      default: ret_of = RET_MAIN;
    endcase
  endfunction : ret_of
endpackage : mip_pkg

/* File: verilog/mip_map_if.sv */
`timescale 1ns/1ns
interface mip_map_if;
  logic [2:0] level;
  logic [3:0] sel;
  logic [5:0] idx;
  logic hit;
  modport mapper(input level, input sel, output idx, output hit);
  modport user(output level, output sel, input idx, input hit);
endinterface : mip_map_if

/* File: verilog/mip_bank_map.sv */
`timescale 1ns/1ns
module mip_bank_map (
  mip_map_if.mapper m
);
  always_comb begin
    m.hit = (m.sel <= mip_pkg::SEL_RET);
    if (m.sel == mip_pkg::SEL_NIA) begin
      m.idx = mip_pkg::nia_of(m.level);
    end else if (m.sel == mip_pkg::SEL_RET) begin
      m.idx = mip_pkg::ret_of(m.level);
    end else if (m.hit) begin
      m.idx = mip_pkg::wr_base(m.level) | {3'h0, m.sel[2:0]};
    end else begin
      m.idx = mip_pkg::wr_base(m.level);
    end
  end
endmodule : mip_bank_map

/* File: sim/mip_att_model.sv */
`timescale 1ns/1ns
module mip_att_model (
  input logic clk,
  input logic [6:0] need,
  input logic slow,
  output logic [6:0] req = 7'h00
);
  logic [6:0] need_q = 7'h00;
  // A slow attachment raises and drops its request one clock late
  always @(posedge clk) begin
    need_q <= need;
    req <= slow ? need_q : need;
  end
endmodule : mip_att_model

/* File: sim/mip_checker.sv */
`timescale 1ns/1ns
module mip_checker (
  input logic clk,
  input logic rst_n,
  input logic clk_en,
  input logic parity_chk,
  input logic bad_addr_chk,
  input logic uprog_chk,
  input logic port_chk,
  input logic instr_boundary,
  input logic level_exit,
  input logic [3:0] reg_sel,
  input logic reg_we,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic [2:0] active_level,
  input logic level_entry,
  input logic [2:0] entry_level,
  input logic [3:0] check_cause,
  input logic [3:0] pending_levels,
  input logic [2:0] l2_source
);
  logic [3:0] cks;
  logic [2:0] top;
  assign cks = {port_chk, uprog_chk, bad_addr_chk, parity_chk};
  assign top = pending_levels[0] ? 3'h0 : pending_levels[1] ? 3'h1 :
               pending_levels[2] ? 3'h2 : pending_levels[3] ? 3'h3 : 3'h4;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_idle: assert property (disable iff (1'b0) !rst_n
    |=> active_level == 3'h4 && pending_levels == 4'h0 && !level_entry) else $error("reset state wrong");
  chk_entry_taken: assert property (clk_en && instr_boundary && !level_exit && top < active_level
    |=> level_entry && entry_level == $past(top)) else $error("preemption missed");
  chk_entry_cause: assert property (level_entry && $past(clk_en)
    |-> $past(top) < $past(active_level) && active_level == entry_level) else $error("entry without cause");
  chk_check_pend: assert property (clk_en && cks != 4'h0
    |=> pending_levels[0] && (check_cause & $past(cks)) == $past(cks)) else $error("check not raised");
  chk_pend_wait: assert property (pending_levels[3] && active_level <= 3'h3
    |=> pending_levels[3]) else $error("blocked request lost");
  chk_l2_onehot: assert property (level_entry && entry_level == 3'h2
    |-> $onehot(l2_source)) else $error("level two source not single");
  chk_reg_unmapped: assert property (clk_en && reg_sel > 4'h9
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_reg_keep: assert property (clk_en && reg_we && reg_sel < 4'h8
    ##1 clk_en && $stable(reg_sel) && $stable(active_level)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("work register lost write");
  cover property (level_entry && entry_level == 3'h0);
  cover property (level_entry && entry_level == 3'h1 && $past(active_level) == 3'h3);
  cover property (clk_en && level_exit && active_level != 3'h4);
endmodule : mip_checker
bind mip_ctrl mip_checker chk_i (.*);

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, slow = 1'b0, reg_we = 1'b0;
  logic parity_chk = 1'b0, bad_addr_chk = 1'b0, uprog_chk = 1'b0, port_chk = 1'b0;
  logic instr_boundary = 1'b0, level_exit = 1'b0, level_entry;
  logic [3:0] reg_sel = 4'h0, check_cause, pending_levels;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d0, d1;
  logic [6:0] need = 7'h00, req;
  logic disk_req, comm_line_adapter_req, kbd_req, prn_req, opt_card_req, opt_reader_req, opt_recorder_req;
  logic [2:0] active_level, entry_level, l2_source, l3_source;
  int err_count = 0, checks = 0, seed = 32'h3fbe_11eb, k;
  assign {opt_recorder_req, opt_reader_req, opt_card_req, prn_req, kbd_req, comm_line_adapter_req, disk_req} = req;
  mip_ctrl uut (.*);
  mip_att_model partner (.*);
  always #20 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Causes are sticky, so after the n-th pulse every earlier cause still shows
  function automatic logic [3:0] exp_cause(input int n);
    exp_cause = 4'((2 << n) - 1);
  endfunction : exp_cause
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic pulse(input logic b, input logic x);
    @(posedge clk);
    instr_boundary <= b;
    level_exit <= x;
    @(posedge clk);
    instr_boundary <= 1'b0;
    level_exit <= 1'b0;
    #1;
  endtask : pulse
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge clk);
    reg_sel <= s;
    reg_we <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] s, input logic [15:0] e);
    @(posedge clk);
    reg_sel <= s;
    @(posedge clk);
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task automatic reset_dut();
    need <= 7'h00;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
  endtask : reset_dut
  task automatic conclude();
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  initial begin
    reset_dut();
    #1;
    chk({pending_levels, check_cause, active_level}, {8'h00, mip_pkg::LVL_MAIN});
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      {port_chk, uprog_chk, bad_addr_chk, parity_chk} <= 4'h1 << k;
      @(posedge clk);
      {port_chk, uprog_chk, bad_addr_chk, parity_chk} <= 4'h0;
      #1;
      chk({pending_levels[0], check_cause}, {1'b1, exp_cause(k)});
    end
    // A request still held at entry pends again, so each source drops it before its turn
    for (int lv = 2; lv < 4; lv++) begin
      reset_dut();
      need <= (lv == 2) ? 7'h0e : 7'h70;
      cyc(6);
      #1;
      chk(pending_levels, 4'h1 << lv);
      for (k = 0; k < 3; k++) begin
        need[((lv == 2) ? 1 : 4) + k] <= 1'b0;
        cyc(5);
        pulse(1'b1, 1'b0);
        chk({level_entry, entry_level, (lv == 2) ? l2_source : l3_source}, {1'b1, 3'(lv), 3'h1 << k});
        if (lv == 3 && k == 0) begin
          wr(4'h7, 16'h5a5a);
          rd(4'h8, 16'h0400);
        end
        if (lv == 3 && k == 1) rd(4'h7, 16'h5a5a);
        pulse(1'b0, 1'b1);
        if (lv == 3 && k == 0) rd(4'h7, 16'h0000);
      end
    end
    reset_dut();
    slow <= 1'b1;
    k = $unsigned($random(seed)) % 8;
    d0 = 16'($random(seed));
    d1 = 16'($random(seed));
    wr(4'(k), d0);
    need <= 7'h10;
    cyc(7);
    pulse(1'b1, 1'b0);
    chk(active_level, 3'h3);
    need <= 7'h01;
    cyc(7);
    pulse(1'b1, 1'b0);
    chk({level_entry, active_level}, {1'b1, 3'h1});
    need <= 7'h00;
    wr(4'(k), d1);
    rd(4'(k), d1);
    rd(4'h8, 16'h0200);
    rd(4'hc, 16'h0000);
    @(posedge clk);
    uprog_chk <= 1'b1;
    @(posedge clk);
    uprog_chk <= 1'b0;
    pulse(1'b1, 1'b0);
    chk({active_level, check_cause}, {3'h0, 4'h4});
    rd(4'(k), d0);
    pulse(1'b0, 1'b1);
    chk(active_level, 3'h1);
    pulse(1'b0, 1'b1);
    chk(active_level, 3'h3);
    // A low enable freezes the exit; an exit beside a boundary defers the pending entry
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(1'b0, 1'b1);
    chk(active_level, 3'h3);
    @(posedge clk);
    clk_en <= 1'b1;
    pulse(1'b1, 1'b1);
    chk({level_entry, active_level}, {1'b0, 3'h4});
    pulse(1'b1, 1'b0);
    chk({level_entry, entry_level, active_level}, {1'b1, 3'h1, 3'h1});
    conclude();
  end
  initial begin
    cyc(5000);
    err_count++;
    conclude();
  end
endmodule : tb_top
